// ==== logic/rics_ctrl.sv ====
/*
 Interrupt control and status byte of the clock, with the interrupt output.
 Assumes the serial port front end delivers one-cycle read/write strobes on sys_clk,
 and that alarm and countdown events are one-cycle pulses on sys_clk.
*/
`timescale 1ns/1ns
`include "rics_map.svh"
// How it works
// - With pulse select at zero the timer interrupt follows the countdown flag as a level.
// - With pulse select at one each countdown interrupt shows as a short pulse.
// - The alarm flag holds at one after an alarm until the host writes zero to it.
// - The countdown flag sets on each countdown interrupt and reads zero before any.
// - The two enables gate alarm and timer sources onto the output and reset to zero.
module rics_ctrl
   import rics_pkg::*;
#(
   parameter int PULSE_CYCLES = `RICS_PULSE_CYCLES
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  rics_req_s       req,
   output logic [7:0]      rdata,
   input  wire logic       alarm_event,
   input  wire logic       countdown_event,
   output logic            irq
);
   // The pulse counter is eight bits wide
   if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_pulse
      $error("PULSE_CYCLES must be 1 to 255");
   end

   rics_ctrl_s ctrl;
   rics_ctrl_s next_ctrl;
   logic [7:0] next_rdata;
   logic       sel;
   logic       tpulse;
   logic       timer_src;

   assign sel = (req.addr == `RICS_REG_OFFSET);

   always_comb begin
      next_ctrl  = ctrl;
      next_rdata = rdata;
      if (req.wr && sel) begin
         // Reserved bits stored as written; the host clears bit 7 itself
         next_ctrl.reserved               = req.wdata[`RICS_BIT_RSVD_HI:`RICS_BIT_RSVD_LO];
         next_ctrl.timer_irq_pulse_select = req.wdata[`RICS_BIT_PULSE_SEL];
         next_ctrl.alarm_irq_enable       = req.wdata[`RICS_BIT_ALARM_IE];
         next_ctrl.countdown_irq_enable   = req.wdata[`RICS_BIT_CD_IE];
         // Flags only clear on a written zero
         next_ctrl.alarm_flag     = ctrl.alarm_flag & req.wdata[`RICS_BIT_ALARM_FLAG];
         next_ctrl.countdown_flag = ctrl.countdown_flag & req.wdata[`RICS_BIT_CD_FLAG];
      end
      // Set wins over a clear in the same cycle
      if (alarm_event) next_ctrl.alarm_flag = 1'b1;
      if (countdown_event) next_ctrl.countdown_flag = 1'b1;
      if (req.rd) begin
         next_rdata = sel ? ctrl : 8'h00;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl  <= `RICS_RESET_VALUE;
         rdata <= 8'h00;
      end else begin
         ctrl  <= next_ctrl;
         rdata <= next_rdata;
      end
   end

   rics_pulse_gen #(
      .WIDTH   (PULSE_CYCLES)
   ) u_pulse (
      .sys_clk (sys_clk),
      .rst     (rst),
      .trigger (countdown_event),
      .pulse   (tpulse)
   );

   // Pulse mode does not wait for the flag to clear
   assign timer_src = ctrl.timer_irq_pulse_select ? tpulse : ctrl.countdown_flag;
   assign irq = (ctrl.alarm_flag & ctrl.alarm_irq_enable)
              | (timer_src & ctrl.countdown_irq_enable);

   property p_alarm_hold;
      @(posedge sys_clk) disable iff (rst)
      ctrl.alarm_flag && !(req.wr && sel && !req.wdata[`RICS_BIT_ALARM_FLAG])
         |=> ctrl.alarm_flag;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag dropped");

   property p_cd_set;
      @(posedge sys_clk) disable iff (rst)
      countdown_event |=> ctrl.countdown_flag;
   endproperty
   a_cd_set: assert property (p_cd_set) else $error("countdown flag not set");

   property p_level;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.timer_irq_pulse_select && ctrl.countdown_irq_enable && !ctrl.alarm_irq_enable
         |-> irq == ctrl.countdown_flag;
   endproperty
   a_level: assert property (p_level) else $error("level mode mismatch");

   property p_pulse;
      @(posedge sys_clk) disable iff (rst)
      ctrl.timer_irq_pulse_select && ctrl.countdown_irq_enable && countdown_event
         && !(req.wr && sel)
         |=> irq;
   endproperty
   a_pulse: assert property (p_pulse) else $error("no timer pulse");

   property p_mask;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.alarm_irq_enable && !ctrl.countdown_irq_enable |-> !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq while disabled");

   property p_write_one;
      @(posedge sys_clk) disable iff (rst)
      req.wr && sel && req.wdata[`RICS_BIT_CD_FLAG] && !countdown_event
         |=> ctrl.countdown_flag == $past(ctrl.countdown_flag);
   endproperty
   a_write_one: assert property (p_write_one) else $error("flag changed by one");

   // An alarm event always sets the alarm flag in the next cycle
   property p_alarm_set;
      @(posedge sys_clk) disable iff (rst)
      alarm_event
         |=> ctrl.alarm_flag;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

   property p_alarm_clear;
      @(posedge sys_clk) disable iff (rst)
      req.wr && sel && !req.wdata[`RICS_BIT_ALARM_FLAG] && !alarm_event
         |=> !ctrl.alarm_flag;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("alarm flag not cleared");

   property p_alarm_keep;
      @(posedge sys_clk) disable iff (rst)
      req.wr && sel && req.wdata[`RICS_BIT_ALARM_FLAG] && !alarm_event
         |=> ctrl.alarm_flag == $past(ctrl.alarm_flag);
   endproperty
   a_alarm_keep: assert property (p_alarm_keep) else $error("alarm flag changed by one");

   property p_alarm_quiet;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.alarm_flag && !alarm_event
         |=> !ctrl.alarm_flag;
   endproperty
   a_alarm_quiet: assert property (p_alarm_quiet) else $error("alarm flag rose alone");

   property p_cd_quiet;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.countdown_flag && !countdown_event
         |=> !ctrl.countdown_flag;
   endproperty
   a_cd_quiet: assert property (p_cd_quiet) else $error("countdown flag rose alone");

   property p_cd_clear;
      @(posedge sys_clk) disable iff (rst)
      req.wr && sel && !req.wdata[`RICS_BIT_CD_FLAG] && !countdown_event
         |=> !ctrl.countdown_flag;
   endproperty
   a_cd_clear: assert property (p_cd_clear) else $error("countdown flag not cleared");

   property p_enables_write;
      @(posedge sys_clk) disable iff (rst)
      req.wr && sel
         |=> ctrl.alarm_irq_enable == $past(req.wdata[`RICS_BIT_ALARM_IE])
             && ctrl.countdown_irq_enable == $past(req.wdata[`RICS_BIT_CD_IE]);
   endproperty
   a_enables_write: assert property (p_enables_write) else $error("enables not stored");

   property p_select_write;
      @(posedge sys_clk) disable iff (rst)
      req.wr && sel
         |=> ctrl.timer_irq_pulse_select == $past(req.wdata[`RICS_BIT_PULSE_SEL]);
   endproperty
   a_select_write: assert property (p_select_write) else $error("select not stored");

   property p_alarm_gate;
      @(posedge sys_clk) disable iff (rst)
      ctrl.alarm_flag && ctrl.alarm_irq_enable
         |-> irq;
   endproperty
   a_alarm_gate: assert property (p_alarm_gate) else $error("alarm irq missing");

   property p_timer_off;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.countdown_irq_enable && !(ctrl.alarm_flag && ctrl.alarm_irq_enable)
         |-> !irq;
   endproperty
   a_timer_off: assert property (p_timer_off) else $error("timer irq while disabled");

   property p_alarm_level;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.timer_irq_pulse_select && ctrl.alarm_irq_enable && ctrl.countdown_irq_enable
         |-> irq == (ctrl.alarm_flag | ctrl.countdown_flag);
   endproperty
   a_alarm_level: assert property (p_alarm_level) else $error("combined level wrong");

   // In pulse mode a set countdown flag alone must not hold the output
   property p_pulse_only;
      @(posedge sys_clk) disable iff (rst)
      ctrl.timer_irq_pulse_select && !tpulse && !(ctrl.alarm_flag && ctrl.alarm_irq_enable)
         |-> !irq;
   endproperty
   a_pulse_only: assert property (p_pulse_only) else $error("timer irq held as level");

   property p_pulse_on;
      @(posedge sys_clk) disable iff (rst)
      ctrl.timer_irq_pulse_select && ctrl.countdown_irq_enable && tpulse
         |-> irq;
   endproperty
   a_pulse_on: assert property (p_pulse_on) else $error("timer pulse not shown");

   property p_read_back;
      @(posedge sys_clk) disable iff (rst)
      req.rd && sel
         |=> rdata == $past(ctrl);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data wrong");
endmodule : rics_ctrl

// ==== pkg/rics_map.svh ====
/*
 Offsets, field positions, reset value and timing counts of the interrupt control byte.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef RICS_MAP_SVH
`define RICS_MAP_SVH
`define RICS_REG_OFFSET      4'h1
`define RICS_RESET_VALUE     8'h80
`define RICS_BIT_RSVD_HI     7
`define RICS_BIT_RSVD_LO     5
`define RICS_BIT_PULSE_SEL   4
`define RICS_BIT_ALARM_FLAG  3
`define RICS_BIT_CD_FLAG     2
`define RICS_BIT_ALARM_IE    1
`define RICS_BIT_CD_IE       0
`define RICS_PULSE_NS        64
`define RICS_CLK_NS          4
`define RICS_PULSE_CYCLES    ((`RICS_PULSE_NS + `RICS_CLK_NS - 1) / `RICS_CLK_NS)
`endif

// ==== pkg/rics_pkg.sv ====
/*
 Types of the interrupt control byte.
 Assumes rics_map.svh is on the include path.
*/
`include "rics_map.svh"
package rics_pkg;
   typedef struct packed {
      logic [2:0] reserved;
      logic       timer_irq_pulse_select;
      logic       alarm_flag;
      logic       countdown_flag;
      logic       alarm_irq_enable;
      logic       countdown_irq_enable;
   } rics_ctrl_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } rics_req_s;

   typedef enum logic [1:0] {
      RICS_IDLE  = 2'b01,
      RICS_PULSE = 2'b10
   } rics_pstate_e;
endpackage : rics_pkg

// ==== logic/rics_pulse_gen.sv ====
/*
 Stretches a one-cycle countdown event into a fixed-width interrupt pulse.
 Assumes the event input is on sys_clk.
*/
`timescale 1ns/1ns
`include "rics_map.svh"
module rics_pulse_gen
   import rics_pkg::*;
#(
   parameter int WIDTH = `RICS_PULSE_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic trigger,
   output logic      pulse
);
   // The counter is eight bits wide, so longer pulses are refused
   if (WIDTH < 1 || WIDTH > 255) begin : g_bad_width
      $error("WIDTH out of range");
   end

   rics_pstate_e state;
   rics_pstate_e next_state;
   logic [7:0]   cnt;
   logic [7:0]   next_cnt;

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         RICS_IDLE: begin
            if (trigger) begin
               next_state = RICS_PULSE;
               next_cnt   = 8'(WIDTH - 1);
            end
         end
         RICS_PULSE: begin
            if (trigger) begin
               next_cnt = 8'(WIDTH - 1);
            end else if (cnt == 8'h00) begin
               next_state = RICS_IDLE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         default: begin
            next_state = RICS_IDLE;
            next_cnt   = 8'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= RICS_IDLE;
         cnt   <= 8'h00;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   assign pulse = (state == RICS_PULSE);

   property p_pulse_start;
      @(posedge sys_clk) disable iff (rst)
      trigger
         |=> pulse && (cnt == 8'(WIDTH - 1));
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

   property p_pulse_stop;
      @(posedge sys_clk) disable iff (rst)
      pulse && (cnt == 8'h00) && !trigger
         |=> !pulse;
   endproperty
   a_pulse_stop: assert property (p_pulse_stop) else $error("pulse did not end");
endmodule : rics_pulse_gen

// ==== sim/rics_host.sv ====
/*
 Host model: one-cycle register write and read strobes.
 Assumes calls from the bench; signals change on falling edges.
*/
`timescale 1ns/1ns
module rics_host
   import rics_pkg::*;
(
   input  wire logic sys_clk,
   output rics_req_s req
);
   initial req = '0;
   task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      req.wr = w;
      req.rd = !w;
      req.addr = a;
      req.wdata = d & 8'h1F; // Reserved bits always zero
      @(negedge sys_clk);
      req.wr = 1'b0;
      req.rd = 1'b0;
      req.wdata = ~req.wdata; // Idle bus shows the complement of the last byte
   endtask : access
endmodule : rics_host

// ==== sim/test_rics_ctrl.sv ====
/*
 Self-checking bench of the interrupt control byte.
 Assumes the host model issues all register requests.
*/
`timescale 1ns/1ns
module test_rics_ctrl
   import rics_pkg::*;
;
   localparam int PC = 4;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        alarm_event = 1'b0;
   logic        countdown_event = 1'b0;
   logic        irq;
   logic [7:0]  rdata;
   logic [7:0]  d;
   logic        rd_d = 1'b0;
   rics_req_s   req;
   logic [7:0]  exp_q[$];
   logic [31:0] lfsr = 32'h0C7B1446;
   int          bad_count = 0;
   int          compares = 0;
   always #2 sys_clk = ~sys_clk;
   rics_host host (.sys_clk(sys_clk), .req(req));
   rics_ctrl #(.PULSE_CYCLES(PC)) uut (.sys_clk(sys_clk), .rst(rst), .req(req),
      .rdata(rdata), .alarm_event(alarm_event), .countdown_event(countdown_event),
      .irq(irq));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd1(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask : rd1
   task automatic ev(input logic al);
      @(negedge sys_clk);
      alarm_event = al;
      countdown_event = !al;
      @(negedge sys_clk);
      alarm_event = 1'b0;
      countdown_event = 1'b0;
      @(negedge sys_clk);
   endtask : ev
   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // Read data lands one cycle after the strobe
   always @(posedge sys_clk) rd_d <= req.rd;
   always @(negedge sys_clk) if (rd_d) chk(rdata, exp_q.pop_front());
   initial begin
      #20000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      rd1(4'h1, 8'h80);
      chk({7'h0, irq}, 8'h00);
      host.access(1'b1, 4'h1, 8'hE0);
      rd1(4'h1, 8'h00);
      ev(1'b0);
      chk({7'h0, irq}, 8'h00);
      rd1(4'h1, 8'h04);
      host.access(1'b1, 4'h1, 8'h05);
      chk({7'h0, irq}, 8'h01);
      host.access(1'b1, 4'h1, 8'h01);
      chk({7'h0, irq}, 8'h00);
      host.access(1'b1, 4'h1, 8'h06);
      rd1(4'h1, 8'h02);
      ev(1'b1);
      chk({7'h0, irq}, 8'h01);
      host.access(1'b1, 4'h1, 8'h0A);
      rd1(4'h1, 8'h0A);
      host.access(1'b1, 4'h1, 8'h02);
      rd1(4'h1, 8'h02);
      chk({7'h0, irq}, 8'h00);
      host.access(1'b1, 4'h1, 8'h11);
      ev(1'b0);
      chk({7'h0, irq}, 8'h01);
      repeat (PC - 2) @(negedge sys_clk);
      chk({7'h0, irq}, 8'h01);
      @(negedge sys_clk);
      chk({7'h0, irq}, 8'h00);
      rd1(4'h1, 8'h15);
      // Clearing write and countdown event in one cycle: the set wins
      fork
         host.access(1'b1, 4'h1, 8'h11);
         ev(1'b0);
      join
      rd1(4'h1, 8'h15);
      // Unmapped places ignore writes and read zero
      repeat (4) begin
         d = rnd();
         host.access(1'b1, {d[3:1], 1'b0}, d);
         rd1({d[3:1], 1'b0}, 8'h00);
      end
      rd1(4'h1, 8'h15);
      repeat (2) @(negedge sys_clk);
      tally_and_finish();
   end
endmodule : test_rics_ctrl
